// file: inc/lfs_pkg.sv
// Package of constants for the LED channel fault supervisor.
// Operation
// [R1] Disable a channel after timeout when its pin is short_threshold above the lowest.
// [R2] Fault timeout lasts six dimming periods; direct dimming may stretch it.
// [R3] An open channel is disabled alone after timeout; others keep running.
// [R4] Channel reaching target current is healthy; healthy channel losing current is open.
// [R5] At output_overvoltage_limit every channel not healthy starts timeout and then switches off.
// [R6] Channels with grounded pins are excluded from start-up and never force overvoltage.
// [R7] Supply below lockout stops switching and resets; recovery restores default settings.
// [R8] Over-temperature stops boost and all channels, latched until enable or power cycles.
// [R9] Input overvoltage shuts down, latched until enable or power cycles, defaults restored.
// [R10] Enable low shuts the whole device down and ignores all activity.
// [R11] Start-up works when enable rises before the supply.
// [R12] Short timeout with three channels already off shuts down all channels.
// [R13] A short below short_threshold is not disabled and keeps driving current.
// [R14] Boost output or switch node grounded at start-up prevents switching.
// [R15] Timeout counter counts dimming periods while fault persists, clears when it goes away.
package lfs_pkg;
  localparam int unsigned LFS_NUM_CH = 4;
  localparam int unsigned LFS_TIMEOUT_PERIODS = 6;
  localparam int unsigned LFS_CNT_W = 3;
  localparam logic [LFS_CNT_W-1:0] LFS_TIMEOUT_CNT = 3'h6;
  localparam logic [LFS_CNT_W-1:0] LFS_CNT_RESET = 3'h0;
  localparam logic [3:0] LFS_MASK_RESET = 4'h0;
  localparam int unsigned LFS_SHUT_LIMIT = 3;
  localparam logic [2:0] LFS_SHUT_LIMIT_W = 3'h3;
endpackage

// file: rtl/lfs_chan_timer.sv
// Per-channel fault timeout counter.
`timescale 1ns/1ns
module lfs_chan_timer
  import lfs_pkg::*;
(
  input wire logic clk, // System clock.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable.
  input wire logic clear, // Synchronous clear (shutdown or restart).
  input wire logic fault, // Fault condition present this cycle.
  input wire logic period_tick, // One-cycle pulse at end of a dimming period.
  output logic expired // Timeout reached, level.
);
  logic [LFS_CNT_W-1:0] cnt_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= LFS_CNT_RESET;
    end else if (ce) begin
      if (clear || !fault) begin
        cnt_q <= LFS_CNT_RESET; // R15
      end else if (period_tick && cnt_q != LFS_TIMEOUT_CNT) begin
        cnt_q <= cnt_q + 3'h1; // R2
      end
    end
  end

  assign expired = fault && (cnt_q == LFS_TIMEOUT_CNT);

  a_cnt_clears_on_ok: assert property (@(posedge clk) disable iff (!rst_b) // R15
    (ce && !fault) |=> (cnt_q == LFS_CNT_RESET))
    else $error("timeout count did not clear when fault went away");

  a_expire_needs_tick: assert property (@(posedge clk) disable iff (!rst_b) // R2
    (ce && fault && !clear && !period_tick && cnt_q != LFS_TIMEOUT_CNT)
    |=> (cnt_q != LFS_TIMEOUT_CNT))
    else $error("timeout advanced without a dimming period");
endmodule // lfs_chan_timer

// file: rtl/lfs_supervisor.sv
// Fault supervisor for a four-channel LED string driver.
`timescale 1ns/1ns
module lfs_supervisor
  import lfs_pkg::*;
(
  input wire logic clk, // 25 MHz clock.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable, freezes all state when low.
  input wire logic enable_in, // Enable pin, high to run.
  input wire logic supply_ok, // Supply above supply_lockout level.
  input wire logic vin_overvoltage, // Input supply above its limit.
  input wire logic over_temp, // Die over-temperature comparator.
  input wire logic output_overvoltage_limit, // Boost output at its limit.
  input wire logic output_shorted, // Boost output or switch node at ground.
  input wire logic period_tick, // Pulse at end of each dimming period.
  input wire logic [3:0] pin_grounded, // Channel pin tied to ground.
  input wire logic [3:0] short_protect, // Pin above lowest by short_threshold.
  input wire logic [3:0] at_target, // Channel current at target.
  output logic [3:0] ch_enable, // Channel current source enable.
  output logic [3:0] ch_healthy, // Channel marked good.
  output logic [3:0] ch_open, // Channel classed open circuit.
  output logic boost_enable, // Boost converter may switch.
  output logic [3:0] ch_fault_off, // Channel timed out and disabled.
  output logic latched_shutdown // Over-temperature or input overvoltage latched.
);
  // ------------------------------------------------------------
  // Run qualification.
  // ------------------------------------------------------------
  // A soft reset restarts all supervision except the latched shutdown; enable may rise before the supply.
  logic run;
  logic soft_clr;
  logic started_q;
  logic lock_q;
  logic all_off_q;
  logic [3:0] excl_q;
  logic [3:0] healthy_q;
  logic [3:0] off_q;
  logic [3:0] fault_c;
  logic [3:0] expired;

  assign soft_clr = !enable_in || !supply_ok; // R7 R10 R11

  // ------------------------------------------------------------
  // Latched shutdown.
  // ------------------------------------------------------------
  // Enable low wins over a new event on the same edge, since the part is off then anyway.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_q <= 1'b0;
    end else if (ce) begin
      if (!enable_in) begin
        lock_q <= 1'b0; // R8 R9
      end else if (over_temp || vin_overvoltage) begin
        lock_q <= 1'b1; // R8 R9
      end
    end
  end

  assign run = enable_in && supply_ok && !lock_q && !all_off_q;

  // ------------------------------------------------------------
  // Start-up capture.
  // ------------------------------------------------------------
  // Grounded pins are sampled once at start-up; a shorted output holds start-up off until it clears and is ignored after.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      started_q <= 1'b0;
      excl_q <= LFS_MASK_RESET;
    end else if (ce) begin
      if (soft_clr) begin
        started_q <= 1'b0;
        excl_q <= LFS_MASK_RESET;
      end else if (!started_q && !output_shorted) begin
        started_q <= 1'b1; // R14
        excl_q <= pin_grounded; // R6
      end
    end
  end

  // ------------------------------------------------------------
  // Health and fault classification.
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      healthy_q <= LFS_MASK_RESET;
    end else if (ce) begin
      if (soft_clr || lock_q) begin
        healthy_q <= LFS_MASK_RESET;
      end else begin
        healthy_q <= healthy_q | (at_target & ~excl_q & ~off_q); // R4
      end
    end
  end

  // Open: healthy lost target, or not yet healthy while output is at its limit.
  assign ch_open = (healthy_q & ~at_target) |
                   ({4{output_overvoltage_limit}} & ~healthy_q); // R4 R5
  // A short below short_threshold simply never raises short_protect.
  assign fault_c = (short_protect | ch_open) & ~excl_q & ~off_q & {4{started_q}}; // R1 R13

  for (genvar i = 0; i < LFS_NUM_CH; i++) begin : g_tmr
    lfs_chan_timer lfs_chan_timer_i (
      .clk(clk),
      .rst_b(rst_b),
      .ce(ce),
      .clear(soft_clr || lock_q),
      .fault(fault_c[i]),
      .period_tick(period_tick),
      .expired(expired[i])
    );
  end

  // ------------------------------------------------------------
  // Channel disable and global short shutdown.
  // ------------------------------------------------------------
  function automatic logic [2:0] lfs_count(input logic [3:0] v);
    lfs_count = {2'b00, v[0]} + {2'b00, v[1]} + {2'b00, v[2]} + {2'b00, v[3]};
  endfunction

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      off_q <= LFS_MASK_RESET;
      all_off_q <= 1'b0;
    end else if (ce) begin
      if (soft_clr) begin
        off_q <= LFS_MASK_RESET;
        all_off_q <= 1'b0;
      end else begin
        off_q <= off_q | expired; // R1 R3 R5
        if (|(expired & short_protect) &&
            lfs_count(off_q | excl_q) >= LFS_SHUT_LIMIT_W) begin
          all_off_q <= 1'b1; // R12
        end
      end
    end
  end

  assign ch_enable = {4{run && started_q}} & ~excl_q & ~off_q; // R3 R6 R8 R10
  assign boost_enable = run && started_q; // R7 R8 R14
  assign ch_healthy = healthy_q;
  assign ch_fault_off = off_q;
  assign latched_shutdown = lock_q;

  // ------------------------------------------------------------
  // Checks.
  // ------------------------------------------------------------
  // Most checks look one edge ahead, so they judge state, not inputs that may move on that edge.
  a_off_after_timeout: assert property (@(posedge clk) disable iff (!rst_b) // R1
    (ce && !soft_clr && expired[0]) |=> off_q[0])
    else $error("expired channel not disabled");

  a_otp_stops_all: assert property (@(posedge clk) disable iff (!rst_b) // R8
    (ce && enable_in && over_temp) |=> (!boost_enable && ch_enable == 4'h0))
    else $error("over-temperature did not stop output");

  a_otp_latches: assert property (@(posedge clk) disable iff (!rst_b) // R8 R9
    (lock_q && enable_in) |=> lock_q)
    else $error("latched shutdown released without enable cycle");

  a_lock_sets: assert property (@(posedge clk) disable iff (!rst_b) // R9
    (ce && enable_in && vin_overvoltage) |=> latched_shutdown)
    else $error("input overvoltage did not latch shutdown");

  a_enable_low_off: assert property (@(posedge clk) disable iff (!rst_b) // R10
    !enable_in |-> (!boost_enable && ch_enable == 4'h0))
    else $error("outputs active while enable low");

  a_enable_clears: assert property (@(posedge clk) disable iff (!rst_b) // R10
    (ce && !enable_in) |=> (!latched_shutdown && ch_fault_off == LFS_MASK_RESET))
    else $error("enable low did not clear latched state");

  a_lockout_off: assert property (@(posedge clk) disable iff (!rst_b) // R7
    (ce && !supply_ok) |=> (!boost_enable && healthy_q == LFS_MASK_RESET))
    else $error("lockout did not reset");

  a_lockout_defaults: assert property (@(posedge clk) disable iff (!rst_b) // R7
    (ce && !supply_ok)
    |=> (off_q == LFS_MASK_RESET && excl_q == LFS_MASK_RESET && !all_off_q))
    else $error("lockout left a setting away from its default");

  a_ground_excluded: assert property (@(posedge clk) disable iff (!rst_b) // R6
    excl_q[1] |-> (!ch_enable[1] && !fault_c[1]))
    else $error("grounded channel was driven");

  a_short_no_start: assert property (@(posedge clk) disable iff (!rst_b) // R14
    !started_q |-> !boost_enable)
    else $error("boost switched before start-up");

  a_start_blocked: assert property (@(posedge clk) disable iff (!rst_b) // R14
    (ce && !started_q && output_shorted) |=> !started_q)
    else $error("start-up went ahead with the output shorted");

  a_healthy_mark: assert property (@(posedge clk) disable iff (!rst_b) // R4
    (ce && !soft_clr && !lock_q && at_target[0] && !excl_q[0] && !off_q[0])
    |=> ch_healthy[0])
    else $error("channel at target not marked healthy");

  a_healthy_sticky: assert property (@(posedge clk) disable iff (!rst_b) // R4
    (ce && !soft_clr && !lock_q && healthy_q[3]) |=> healthy_q[3])
    else $error("healthy mark lost while running");

  a_ovl_times_out: assert property (@(posedge clk) disable iff (!rst_b) // R5
    (started_q && output_overvoltage_limit && !healthy_q[2] && !excl_q[2] && !off_q[2])
    |-> fault_c[2])
    else $error("channel not healthy did not time out at the output limit");

  a_off_holds: assert property (@(posedge clk) disable iff (!rst_b) // R3
    (ce && !soft_clr && off_q[1]) |=> off_q[1])
    else $error("disabled channel came back without a restart");

  a_others_run: assert property (@(posedge clk) disable iff (!rst_b) // R3
    (ce && !soft_clr && expired[1] && !short_protect[1] && !expired[0] && !off_q[0])
    |=> !off_q[0])
    else $error("open fault disturbed another channel");

  a_shut_all: assert property (@(posedge clk) disable iff (!rst_b) // R12
    (ce && !soft_clr && |(expired & short_protect) &&
     $countones(off_q | excl_q) >= LFS_SHUT_LIMIT) |=> (ch_enable == 4'h0))
    else $error("channels still on after global short shutdown");

  a_freeze_holds: assert property (@(posedge clk) disable iff (!rst_b)
    !ce |=> ($stable(off_q) && $stable(lock_q) && $stable(healthy_q) && $stable(started_q)))
    else $error("state moved while clock enable was low");
endmodule // lfs_supervisor

// file: dv/lfs_analog_model.sv
// Behavioural model of the channel comparators and current sources.
`timescale 1ns/1ns
module lfs_analog_model (
  input wire logic [3:0] ch_enable, // Current source enables.
  input wire logic boost_enable, // Boost may switch.
  input wire logic [3:0] string_open, // Strings the bench breaks open.
  input wire logic [3:0] string_short, // Strings the bench shorts.
  output logic [3:0] at_target, // Current reached target.
  output logic [3:0] short_protect, // Pin far above the lowest.
  output logic output_overvoltage_limit // Boost output at limit.
);
  // An open string never regulates, so an enabled one drives the output to its limit.
  assign at_target = boost_enable ? (ch_enable & ~string_open) : 4'h0;
  assign short_protect = ch_enable & string_short;
  assign output_overvoltage_limit = boost_enable && ((ch_enable & string_open) != 4'h0);
endmodule // lfs_analog_model

// file: dv/test_lfs_supervisor.sv
// Self-checking bench for the LED channel fault supervisor.
`timescale 1ns/1ns
module test_lfs_supervisor;
  logic clk, rst_b, ce, enable_in, supply_ok, vin_ov, over_temp, out_short, period_tick;
  logic [3:0] pin_grounded, s_open, s_short, short_protect, at_target;
  logic [3:0] ch_enable, ch_healthy, ch_open, ch_fault_off;
  logic ovl, boost_enable, latched_shutdown;
  int failures, checks_done;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  lfs_analog_model lfs_analog_model_i (.ch_enable(ch_enable), .boost_enable(boost_enable),
    .string_open(s_open), .string_short(s_short), .at_target(at_target),
    .short_protect(short_protect), .output_overvoltage_limit(ovl));
  lfs_supervisor lfs_supervisor_i (.clk(clk), .rst_b(rst_b), .ce(ce),
    .enable_in(enable_in), .supply_ok(supply_ok), .vin_overvoltage(vin_ov),
    .over_temp(over_temp), .output_overvoltage_limit(ovl), .output_shorted(out_short),
    .period_tick(period_tick), .pin_grounded(pin_grounded), .short_protect(short_protect),
    .at_target(at_target), .ch_enable(ch_enable), .ch_healthy(ch_healthy),
    .ch_open(ch_open), .boost_enable(boost_enable), .ch_fault_off(ch_fault_off),
    .latched_shutdown(latched_shutdown));
  task automatic summarize();
    if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      period_tick = 1'b1;
      cyc(1);
      period_tick = 1'b0;
      cyc(1);
    end
  endtask
  // Cycling enable is the only way out of a latched shutdown, so scn_shut_all, scn_freeze and scn_latch start here.
  task automatic restart(input logic [3:0] gnd);
    int i;
    enable_in = 1'b0;
    cyc(2);
    pin_grounded = gnd;
    enable_in = 1'b1;
    for (i = 0; i < 10 && boost_enable !== 1'b1; i++) cyc(1);
    if (boost_enable !== 1'b1) begin
      failures++;
      summarize();
    end
    cyc(3);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic scn_short();
    s_short = 4'h1;
    ticks(5);
    s_short = 4'h0;
    cyc(2);
    s_short = 4'h1;
    ticks(5);
    chk(ch_fault_off, 4'h0);
    ticks(1);
    cyc(2);
    chk(ch_fault_off, 4'h1);
    chk(ch_enable, 4'he);
    supply_ok = 1'b0;
    cyc(2);
    chk({3'h0, boost_enable}, 4'h0);
    s_short = 4'h0;
    supply_ok = 1'b1;
    cyc(6);
    chk(ch_enable, 4'hf);
    chk(ch_fault_off, 4'h0);
  endtask
  task automatic scn_open();
    s_open = 4'h2;
    cyc(2);
    chk(ch_open, 4'h2);
    ticks(6);
    cyc(2);
    chk(ch_enable, 4'hd);
    s_open = 4'h4;
    restart(4'h8);
    chk(ch_healthy, 4'h3);
    ticks(6);
    cyc(2);
    chk(ch_fault_off, 4'h4);
    chk({3'h0, ovl}, 4'h0);
    s_open = 4'h0;
  endtask
  // Two open strings time out first and channel 3 is grounded, so the later short finds three channels already off.
  task automatic scn_shut_all();
    s_open = 4'h6;
    restart(4'h8);
    ticks(6);
    cyc(2);
    chk(ch_fault_off, 4'h6);
    s_short = 4'h1;
    ticks(6);
    cyc(2);
    chk(ch_fault_off, 4'h7);
    chk(ch_enable, 4'h0);
    chk({3'h0, boost_enable}, 4'h0);
    {s_open, s_short} = 8'h00;
  endtask
  task automatic scn_freeze();
    restart(4'h0);
    s_short = 4'h1;
    ce = 1'b0;
    ticks(8);
    chk(ch_fault_off, 4'h0);
    ce = 1'b1;
    ticks(6);
    cyc(2);
    chk(ch_fault_off, 4'h1);
    s_short = 4'h0;
  endtask
  task automatic scn_latch();
    for (int k = 0; k < 2; k++) begin
      restart(4'h0);
      over_temp = (k == 0);
      vin_ov = (k == 1);
      cyc(2);
      over_temp = 1'b0;
      vin_ov = 1'b0;
      cyc(3);
      chk({latched_shutdown, boost_enable, 2'h0}, 4'h8);
      chk(ch_enable, 4'h0);
      enable_in = 1'b0;
      cyc(2);
      chk({3'h0, latched_shutdown}, 4'h0);
    end
    out_short = 1'b1;
    enable_in = 1'b1;
    cyc(6);
    chk({3'h0, boost_enable}, 4'h0);
    out_short = 1'b0;
  endtask
  initial begin
    failures = 0;
    checks_done = 0;
    rst_b = 1'b0;
    enable_in = 1'b1;
    supply_ok = 1'b0;
    ce = 1'b1;
    {vin_ov, over_temp, out_short, period_tick} = 4'h0;
    {pin_grounded, s_open, s_short} = 12'h000;
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    cyc(3);
    chk({3'h0, boost_enable}, 4'h0);
    supply_ok = 1'b1;
    cyc(5);
    chk(ch_healthy, 4'hf);
    scn_short();
    scn_open();
    scn_shut_all();
    scn_freeze();
    scn_latch();
    summarize();
  end
endmodule // test_lfs_supervisor
